/* File: core/cps_alu_if.sv */
// carrier between the state top and its flag alu
// assumes one driver per side as given by the modports
interface cps_alu_if;
  import cps_pkg::*;

  logic [15:0] opa;
  logic [15:0] opb;
  cps_alu_op_t op;
  logic        wide;
  logic [15:0] res;
  logic        fh;
  logic        fn;
  logic        fz;
  logic        fv;
  logic        fc;

  modport core (output opa, opb, op, wide,
                input  res, fh, fn, fz, fv, fc);
  modport alu  (input  opa, opb, op, wide,
                output res, fh, fn, fz, fv, fc);
endinterface

/* File: core/cps_cfg.svh */
// constants of the cpu state block
// included by the state top, its only user
`ifndef CPS_CFG_SVH
`define CPS_CFG_SVH

// axi4-lite byte offsets
`define CPS_OFF_INSTRUCTION_POINTER 8'h00
`define CPS_OFF_MAIN_ACCUMULATOR    8'h04
`define CPS_OFF_SECOND_OPERAND      8'h08
`define CPS_OFF_INDEX_MODIFIER      8'h0C
`define CPS_OFF_MEMORY_POINTER      8'h10
`define CPS_OFF_STACK_TOP_POINTER   8'h14
`define CPS_OFF_STATUS_WORD         8'h18
`define CPS_OFF_BANK_MIRROR         8'h1C

// write-back destination codes
`define CPS_SEL_INSTRUCTION_POINTER 3'h0
`define CPS_SEL_MAIN_ACCUMULATOR    3'h1
`define CPS_SEL_SECOND_OPERAND      3'h2
`define CPS_SEL_INDEX_MODIFIER      3'h3
`define CPS_SEL_MEMORY_POINTER      3'h4
`define CPS_SEL_STACK_TOP_POINTER   3'h5
`define CPS_SEL_STATUS_WORD         3'h6

// status word field positions
`define CPS_PS_RP_HI   15
`define CPS_PS_RP_LO   11
`define CPS_PS_DP_HI   10
`define CPS_PS_DP_LO   8
`define CPS_PS_H       7
`define CPS_PS_I       6
`define CPS_PS_IL_HI   5
`define CPS_PS_IL_LO   4
`define CPS_PS_N       3
`define CPS_PS_Z       2
`define CPS_PS_V       1
`define CPS_PS_C       0

// flag update mask bits
`define CPS_FM_H 4
`define CPS_FM_N 3
`define CPS_FM_Z 2
`define CPS_FM_V 1
`define CPS_FM_C 0

// reset values
`define CPS_RST_WORD   16'h0000
`define CPS_RST_PS     16'h0030
`define CPS_RST_MIRROR 8'h00

// memory map
`define CPS_IO_MIRROR_ADDR 16'h0078
`define CPS_DIR_WIN_BASE   16'h0080
`define CPS_BANK_BASE      16'h0100
`define CPS_DP_NONE        3'h0

// axi response codes
`define CPS_RESP_OKAY   2'h0
`define CPS_RESP_SLVERR 2'h2

`endif

/* File: core/cps_flag_alu.sv */
// flag alu: result and the five arithmetic flags of accumulator and
// second operand; purely combinational, the state top registers it
module cps_flag_alu
  import cps_pkg::*;
(
  cps_alu_if.alu bus
);

  logic [15:0] a;
  logic [15:0] b;
  logic [16:0] full;
  logic        ms_a;
  logic        ms_b;
  logic        ms_r;

  // narrow ops see only the low byte of each operand
  always_comb begin
    a    = bus.wide ? bus.opa : {8'h00, bus.opa[7:0]};
    b    = bus.wide ? bus.opb : {8'h00, bus.opb[7:0]};
    full = 17'h00000;
    bus.fc = 1'b0;
    unique case (bus.op)
      CPS_OP_ADD: begin
        full   = {1'b0, a} + {1'b0, b};
        bus.fc = bus.wide ? full[16] : full[8];
      end
      CPS_OP_SUB: begin
        full   = {1'b0, a} - {1'b0, b};
        bus.fc = bus.wide ? full[16] : full[8];
      end
      CPS_OP_SHL: begin
        full   = {1'b0, a[15:0] << 1};
        bus.fc = bus.wide ? a[15] : a[7]; // shifted-out bit
      end
      CPS_OP_SHR: begin
        full   = {1'b0, a >> 1};
        bus.fc = a[0]; // shifted-out bit
      end
      CPS_OP_PASS: begin
        full   = {1'b0, b};
      end
    endcase
    bus.res = bus.wide ? full[15:0] : {8'h00, full[7:0]};
    ms_a = bus.wide ? a[15] : a[7];
    ms_b = bus.wide ? b[15] : b[7];
    ms_r = bus.wide ? full[15] : full[7];
    // carry or borrow between bit 3 and bit 4
    bus.fh = (bus.op == CPS_OP_ADD || bus.op == CPS_OP_SUB) &&
             (a[4] ^ b[4] ^ full[4]);
    bus.fn = ms_r;
    bus.fz = bus.wide ? (full[15:0] == 16'h0000)
                      : (full[7:0] == 8'h00);
    // two's complement overflow
    unique case (bus.op)
      CPS_OP_ADD: bus.fv = (ms_a == ms_b) && (ms_r != ms_a);
      CPS_OP_SUB: bus.fv = (ms_a != ms_b) && (ms_r != ms_a);
      default:    bus.fv = 1'b0;
    endcase
  end

endmodule

/* File: core/cps_pkg.sv */
// types of the cpu state block: alu operations and the registered state
// assumes the includer of cps_cfg.svh uses the same field layout
package cps_pkg;

  // alu operation codes, one-hot
  typedef enum logic [4:0] {
    CPS_OP_ADD  = 5'h01,
    CPS_OP_SUB  = 5'h02,
    CPS_OP_SHL  = 5'h04,
    CPS_OP_SHR  = 5'h08,
    CPS_OP_PASS = 5'h10
  } cps_alu_op_t;

  // every flip-flop of the state top
  typedef struct packed {
    logic [15:0] instruction_pointer;
    logic [15:0] main_accumulator;
    logic [15:0] second_operand_register;
    logic [15:0] index_modifier;
    logic [15:0] memory_pointer_extra;
    logic [15:0] stack_top_pointer;
    logic [15:0] processor_status_word;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] dir_map_addr;
    logic [15:0] bank_slot_addr;
    logic        irq_take;
    logic [7:0]  io_rdata;
  } cps_state_t;

endpackage

/* File: core/cps_state_top.sv */
// cpu architectural state: dedicated registers, flags, bank mapping and
// interrupt gating, with an axi4-lite slave for software access
// assumes the execution unit drives the ex_* and alu_* ports synchronously
// to clk_sys_i and keeps its own ordering of instructions
//
// Contract
// - 64-Kbyte space: io, data and program areas, bank and vector areas.
// - 16-bit program counter points at the instruction being fetched.
// - 16-bit accumulator; 8-bit instructions use only its low byte.
// - 16-bit temporary accumulator is second operand; 8-bit uses low byte.
// - 16-bit index register, extra memory pointer and stack pointer.
// - status word: bank pointers in upper byte, condition flags lower.
// - direct addresses 0080h-00FFh redirect to a 128-byte selected area.
// - direct pointer resets 000 unmapped; 001-111 map 0100h up to 0400h.
// - half carry set on carry or borrow between bit 3 and bit 4.
// - interrupt enable permits when 1, blocks when 0, cleared at reset.
// - request taken only if its level beats the 2-bit current level.
// - negative flag copies the result's most significant bit.
// - zero flag set on a zero result, cleared otherwise.
// - overflow flag set on two's complement overflow, else cleared.
// - carry from bit 7 carry or borrow; shifts load the shifted-out bit; 16-bit add and sub here carry from bit 15.
// - general registers: eight bytes per bank, 32 banks, slot by opcode.
// - bank and direct pointers mirrored read/write at io byte 0078h.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`include "cps_cfg.svh"

module cps_state_top
  import cps_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,

  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,

  // execution write-back of a whole register
  input  wire logic        ex_we_i,
  input  wire logic [2:0]  ex_sel_i,
  input  wire logic [15:0] ex_data_i,

  // alu step: accumulator op second operand, result to accumulator
  input  wire logic        alu_go_i,
  input  wire cps_alu_op_t alu_op_i,
  input  wire logic        alu_wide_i,
  input  wire logic [4:0]  alu_fmask_i,

  // core-side io byte access
  input  wire logic        io_we_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic [7:0]       io_rdata_o,

  // address conversion requests
  input  wire logic [7:0]  dir_addr_i,
  input  wire logic [2:0]  slot_sel_i,
  output logic [15:0]      dir_map_addr_o,
  output logic [15:0]      bank_slot_addr_o,

  // interrupt gating
  input  wire logic        irq_req_i,
  input  wire logic [1:0]  irq_level_i,
  output logic             irq_take_o,

  // architectural state seen by the core
  output logic [15:0]      instruction_pointer_o,
  output logic [15:0]      main_accumulator_o,
  output logic [15:0]      second_operand_o,
  output logic [15:0]      index_modifier_o,
  output logic [15:0]      memory_pointer_extra_o,
  output logic [15:0]      stack_top_pointer_o,
  output logic [15:0]      processor_status_word_o
);

  cps_state_t st_r;
  cps_state_t st_nxt;
  cps_alu_if  alu_bus ();

  // flag alu works on the registered operands
  assign alu_bus.opa  = st_r.main_accumulator;
  assign alu_bus.opb  = st_r.second_operand_register;
  assign alu_bus.op   = alu_op_i;
  assign alu_bus.wide = alu_wide_i;

  cps_flag_alu u_alu (
    .bus (alu_bus)
  );

  // merge a 16-bit register with the two low byte lanes of a bus write
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end

    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // mirror byte: bank pointer above direct pointer, as in the status word
  function automatic logic [7:0] mirror_of(input logic [15:0] ps);
    return ps[`CPS_PS_RP_HI:`CPS_PS_DP_LO];
  endfunction

  // register read mux; unmapped offsets answer slverr
  function automatic logic [33:0] read_word(input cps_state_t s,
                                            input logic [7:0] adr);
    logic [33:0] r;
    r = {`CPS_RESP_OKAY, 32'h00000000};
    unique case (adr)
      `CPS_OFF_INSTRUCTION_POINTER:
        r[15:0] = s.instruction_pointer;
      `CPS_OFF_MAIN_ACCUMULATOR:    r[15:0] = s.main_accumulator;
      `CPS_OFF_SECOND_OPERAND:      r[15:0] = s.second_operand_register;
      `CPS_OFF_INDEX_MODIFIER:      r[15:0] = s.index_modifier;
      `CPS_OFF_MEMORY_POINTER:      r[15:0] = s.memory_pointer_extra;
      `CPS_OFF_STACK_TOP_POINTER:   r[15:0] = s.stack_top_pointer;
      `CPS_OFF_STATUS_WORD:         r[15:0] = s.processor_status_word;
      `CPS_OFF_BANK_MIRROR:
        r[7:0] = mirror_of(s.processor_status_word);
      default:                      r[33:32] = `CPS_RESP_SLVERR;
    endcase
    return r;
  endfunction

  logic [33:0] rd_word;

  logic [15:0] ps_v;
  logic [2:0]  dp_v;
  logic [4:0]  rp_v;
  logic [1:0]  il_v;

  // next-state logic for the whole block
  always_comb begin
    st_nxt    = st_r;
    rd_word   = read_word(st_r, s_axi_araddr_i);

    // write address and data are taken independently
    if (s_axi_awvalid_i && st_r.awready) begin
      st_nxt.awready = 1'b0;
      st_nxt.awaddr  = s_axi_awaddr_i;
    end

    if (s_axi_wvalid_i && st_r.wready) begin
      st_nxt.wready = 1'b0;
      st_nxt.wdata  = s_axi_wdata_i;
      st_nxt.wstrb  = s_axi_wstrb_i;
    end
    // both halves held and no response pending: perform the write
    if (!st_r.awready && !st_r.wready && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `CPS_RESP_OKAY;
      unique case (st_r.awaddr)
        `CPS_OFF_INSTRUCTION_POINTER: st_nxt.instruction_pointer =
          lane_merge(st_r.instruction_pointer, st_r.wdata, st_r.wstrb);
        `CPS_OFF_MAIN_ACCUMULATOR: st_nxt.main_accumulator =
          lane_merge(st_r.main_accumulator, st_r.wdata, st_r.wstrb);
        `CPS_OFF_SECOND_OPERAND: st_nxt.second_operand_register =
          lane_merge(st_r.second_operand_register, st_r.wdata,
                     st_r.wstrb);
        `CPS_OFF_INDEX_MODIFIER: st_nxt.index_modifier =
          lane_merge(st_r.index_modifier, st_r.wdata, st_r.wstrb);
        `CPS_OFF_MEMORY_POINTER: st_nxt.memory_pointer_extra =
          lane_merge(st_r.memory_pointer_extra, st_r.wdata, st_r.wstrb);
        `CPS_OFF_STACK_TOP_POINTER: st_nxt.stack_top_pointer =
          lane_merge(st_r.stack_top_pointer, st_r.wdata, st_r.wstrb);
        `CPS_OFF_STATUS_WORD: st_nxt.processor_status_word =
          lane_merge(st_r.processor_status_word, st_r.wdata,
                     st_r.wstrb);
        `CPS_OFF_BANK_MIRROR: begin
          if (st_r.wstrb[0]) begin
            st_nxt.processor_status_word[`CPS_PS_RP_HI:`CPS_PS_DP_LO] =
              st_r.wdata[7:0];
          end
        end
        default: st_nxt.bresp = `CPS_RESP_SLVERR;
      endcase
    end
    // response taken: reopen both write channels
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end

    // read: answer one cycle after the address is taken
    if (s_axi_arvalid_i && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = rd_word[31:0];
      st_nxt.rresp   = rd_word[33:32];
    end

    if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // core-side io write of the mirror byte
    if (io_we_i && io_addr_i == `CPS_IO_MIRROR_ADDR) begin
      st_nxt.processor_status_word[`CPS_PS_RP_HI:`CPS_PS_DP_LO] =
        io_wdata_i;
    end

    // execution write-back of a whole register wins over software
    if (ex_we_i) begin
      unique case (ex_sel_i)
        `CPS_SEL_INSTRUCTION_POINTER:
          st_nxt.instruction_pointer = ex_data_i;
        `CPS_SEL_MAIN_ACCUMULATOR:
          st_nxt.main_accumulator = ex_data_i;
        `CPS_SEL_SECOND_OPERAND:
          st_nxt.second_operand_register = ex_data_i;
        `CPS_SEL_INDEX_MODIFIER:
          st_nxt.index_modifier = ex_data_i;
        `CPS_SEL_MEMORY_POINTER:
          st_nxt.memory_pointer_extra = ex_data_i;
        `CPS_SEL_STACK_TOP_POINTER:
          st_nxt.stack_top_pointer = ex_data_i;
        `CPS_SEL_STATUS_WORD:
          st_nxt.processor_status_word = ex_data_i;
        default: st_nxt.instruction_pointer = st_nxt.instruction_pointer;
      endcase
    end

    // alu step: result and masked flags land in the same edge
    if (alu_go_i) begin
      if (alu_wide_i) begin
        st_nxt.main_accumulator = alu_bus.res;
      end else begin
        st_nxt.main_accumulator[7:0] = alu_bus.res[7:0];
      end

      if (alu_fmask_i[`CPS_FM_H]) begin
        st_nxt.processor_status_word[`CPS_PS_H] = alu_bus.fh;
      end

      if (alu_fmask_i[`CPS_FM_N]) begin
        st_nxt.processor_status_word[`CPS_PS_N] = alu_bus.fn;
      end

      if (alu_fmask_i[`CPS_FM_Z]) begin
        st_nxt.processor_status_word[`CPS_PS_Z] = alu_bus.fz;
      end

      if (alu_fmask_i[`CPS_FM_V]) begin
        st_nxt.processor_status_word[`CPS_PS_V] = alu_bus.fv;
      end

      if (alu_fmask_i[`CPS_FM_C]) begin
        st_nxt.processor_status_word[`CPS_PS_C] = alu_bus.fc;
      end
    end

    // conversions use the current status word
    ps_v = st_r.processor_status_word;
    dp_v = ps_v[`CPS_PS_DP_HI:`CPS_PS_DP_LO];
    rp_v = ps_v[`CPS_PS_RP_HI:`CPS_PS_RP_LO]; // 5-bit pointer
    il_v = ps_v[`CPS_PS_IL_HI:`CPS_PS_IL_LO];

    // direct window remap; low half and pointer 000 pass through
    if (dir_addr_i[7] && dp_v != `CPS_DP_NONE) begin
      st_nxt.dir_map_addr = {6'h00, dp_v, dir_addr_i[6:0]} +
                            `CPS_DIR_WIN_BASE;
    end else begin
      st_nxt.dir_map_addr = {8'h00, dir_addr_i};
    end

    // general register slot: 8 bytes per bank, slot from opcode bits
    st_nxt.bank_slot_addr = {8'h00, rp_v, slot_sel_i} +
                            `CPS_BANK_BASE;

    // accept only with enable set and a strictly higher priority level
    st_nxt.irq_take = irq_req_i && ps_v[`CPS_PS_I] &&
                      (irq_level_i < il_v);

    // core-side read of the mirror byte; other io bytes read zero
    st_nxt.io_rdata = (io_addr_i == `CPS_IO_MIRROR_ADDR) ?
                      mirror_of(ps_v) : `CPS_RST_MIRROR;
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      st_r                         <= '0; // data registers clear to zero
      st_r.processor_status_word   <= `CPS_RST_PS;

      st_r.awready                 <= 1'b1;
      st_r.wready                  <= 1'b1;
      st_r.arready                 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready_o         = st_r.awready;
  assign s_axi_wready_o          = st_r.wready;
  assign s_axi_bvalid_o          = st_r.bvalid;
  assign s_axi_bresp_o           = st_r.bresp;
  assign s_axi_arready_o         = st_r.arready;
  assign s_axi_rvalid_o          = st_r.rvalid;
  assign s_axi_rdata_o           = st_r.rdata;
  assign s_axi_rresp_o           = st_r.rresp;

  assign io_rdata_o              = st_r.io_rdata;

  assign dir_map_addr_o          = st_r.dir_map_addr;
  assign bank_slot_addr_o        = st_r.bank_slot_addr;
  assign irq_take_o              = st_r.irq_take;

  assign instruction_pointer_o   = st_r.instruction_pointer;
  assign main_accumulator_o      = st_r.main_accumulator;
  assign second_operand_o        = st_r.second_operand_register;
  assign index_modifier_o        = st_r.index_modifier;
  assign memory_pointer_extra_o  = st_r.memory_pointer_extra;
  assign stack_top_pointer_o     = st_r.stack_top_pointer;
  assign processor_status_word_o = st_r.processor_status_word;

endmodule

/* File: tb/cps_state_top_chk.sv */
// checker of the cpu state top
// assumes it is bound into the state top and sees only its ports
module cps_state_chk
  import cps_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        ex_we_i,
  input wire logic [2:0]  ex_sel_i,
  input wire logic [15:0] ex_data_i,
  input wire logic        alu_go_i,
  input wire logic        alu_wide_i,
  input wire logic [4:0]  alu_fmask_i,
  input wire logic        io_we_i,
  input wire logic [7:0]  dir_addr_i,
  input wire logic [2:0]  slot_sel_i,
  input wire logic [15:0] dir_map_addr_o,
  input wire logic [15:0] bank_slot_addr_o,
  input wire logic        irq_req_i,
  input wire logic [1:0]  irq_level_i,
  input wire logic        irq_take_o,
  input wire logic [15:0] main_accumulator_o,
  input wire logic [15:0] processor_status_word_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] sw;
  logic [15:0] dir_exp;
  logic [15:0] slot_exp;
  logic        irq_ok;
  logic        alu_only;

  // expected values
  assign sw       = processor_status_word_o;
  assign dir_exp  = (dir_addr_i[7] && sw[10:8] != 3'h0) ?
                    {6'h00, sw[10:8], dir_addr_i[6:0]} + 16'h0080 :
                    {8'h00, dir_addr_i};
  assign slot_exp = 16'h0100 + {8'h00, sw[15:11], slot_sel_i};
  assign irq_ok   = irq_req_i && sw[6] && (irq_level_i < sw[5:4]);
  // alu step alone
  assign alu_only = alu_go_i && !ex_we_i && !io_we_i && s_axi_awready_o
                    && s_axi_wready_o;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // write taken, response two edges on
  sequence wr_take_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence resp_s;
    !s_axi_bvalid_o ##1 s_axi_bvalid_o;
  endsequence

  chk_write_resp: assert property (wr_take_s |=> resp_s)
    else $error("late write response");
  chk_irq_take: assert property (irq_ok |=> irq_take_o)
    else $error("request not taken");
  chk_irq_block: assert property (!irq_ok |=> !irq_take_o)
    else $error("blocked request taken");
  chk_dir_map: assert property (
    1'b1 |=> dir_map_addr_o == $past(dir_exp))
    else $error("bad direct map");
  chk_slot_addr: assert property (
    1'b1 |=> bank_slot_addr_o == $past(slot_exp))
    else $error("bad slot address");
  chk_acc_write: assert property (
    ex_we_i && ex_sel_i == 3'h1 && !alu_go_i
    |=> main_accumulator_o == $past(ex_data_i))
    else $error("acc write lost");
  chk_zero_flag: assert property (
    alu_only && alu_fmask_i[2] |=> sw[2] == ($past(alu_wide_i) ?
    main_accumulator_o == 16'h0000 : main_accumulator_o[7:0] == 8'h00))
    else $error("bad zero flag");
  chk_neg_flag: assert property (
    alu_only && alu_fmask_i[3] |=> sw[3] == ($past(alu_wide_i) ?
    main_accumulator_o[15] : main_accumulator_o[7]))
    else $error("bad negative flag");
  chk_flag_hold: assert property (
    alu_only && !alu_fmask_i[0] |=> sw[0] == $past(sw[0]))
    else $error("masked carry flag changed");
endmodule

bind cps_state_top cps_state_chk chk_i (.*);

/* File: tb/cpu_state_and_bank_mapping_bench.sv */
// self-checking bench of the cpu state top
// assumes design and checker compiled first
module cpu_state_and_bank_mapping_bench
  import cps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i, rst_b_i, ex_we_i, alu_go_i, alu_wide_i, io_we_i;
  logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i, irq_req_i, irq_take_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, irq_level_i, rsp;
  logic [2:0]  ex_sel_i, slot_sel_i;
  logic [3:0]  s_axi_wstrb_i;
  logic [4:0]  alu_fmask_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, io_wdata_i, io_rdata_o;
  logic [7:0]  dir_addr_i;
  logic [15:0] ex_data_i, io_addr_i, dir_map_addr_o, bank_slot_addr_o;
  logic [15:0] instruction_pointer_o, main_accumulator_o, second_operand_o;
  logic [15:0] index_modifier_o, memory_pointer_extra_o;
  logic [15:0] stack_top_pointer_o, processor_status_word_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  cps_alu_op_t alu_op_i;
  int          num_errors, comparisons;

  // alu cases: operation, width, operand, result and flags h n z v c
  localparam cps_alu_op_t OPS [11] = '{CPS_OP_ADD, CPS_OP_ADD, CPS_OP_ADD,
    CPS_OP_SUB, CPS_OP_SUB, CPS_OP_SHL, CPS_OP_SHR, CPS_OP_ADD, CPS_OP_ADD,
    CPS_OP_PASS, CPS_OP_ADD};
  localparam logic [10:0] WIDE = 11'h180;
  localparam logic [15:0] ACC_IN [11] = '{16'h120F, 16'h127F, 16'h12FF,
    16'h1200, 16'h1280, 16'h1281, 16'h1201, 16'hFFFF, 16'h7FFF, 16'h12AA,
    16'h120F};
  localparam logic [15:0] ACC_OUT [11] = '{16'h1210, 16'h1280, 16'h1200,
    16'h12FF, 16'h127F, 16'h1202, 16'h1200, 16'h0000, 16'h8000, 16'h1200,
    16'h1210};
  localparam logic [4:0] FLG [11] = '{5'h10, 5'h1A, 5'h15, 5'h19, 5'h12,
    5'h01, 5'h05, 5'h15, 5'h1A, 5'h04, 5'h11};

  // design under test
  cps_state_top uut (.*);

  // 10 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one register bus write
  task automatic axi_wr(input logic [7:0] adr, input logic [31:0] d,
                        input logic [3:0] s);
    @(posedge clk_sys_i);
    s_axi_awaddr_i  <= adr;
    s_axi_wdata_i   <= d;
    s_axi_wstrb_i   <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o)
        s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  // one read on the register bus
  task automatic axi_rd(input logic [7:0] adr);
    @(posedge clk_sys_i);
    s_axi_araddr_i  <= adr;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o)
        s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    rd = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  // execution write-back of one whole register
  task automatic ex_wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_sys_i);
    ex_we_i   <= 1'b1;
    ex_sel_i  <= s;
    ex_data_i <= d;
    @(posedge clk_sys_i);
    ex_we_i   <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic sc_reset;
    check("status", 32'h0030, processor_status_word_o);
    check("take", 32'h0, irq_take_o);
    axi_rd(8'h00);
    check("ip", 32'h0, rd);
  endtask

  // every register written and read back, a lane write, a bad offset
  task automatic sc_regs;
    logic [15:0] v;
    for (int i = 0; i < 7; i++) begin
      v = 16'(16'h1357 + 16'h1111 * i);
      axi_wr(8'(i * 4), {16'hFFFF, v}, 4'hF);
      check("bresp", 32'h0, rsp);
      axi_rd(8'(i * 4));
      check("rdata", {16'h0000, v}, rd);
    end
    axi_wr(8'h04, 32'h0000_BE00, 4'h2);
    check("acc lane", 32'hBE68, main_accumulator_o);
    axi_wr(8'h20, 32'h0000_0000, 4'hF);
    check("bad bresp", 32'h2, rsp);
    axi_rd(8'h20);
    check("bad rresp", 32'h2, rsp);
  endtask

  // bank pointers through the mirror byte from both sides
  task automatic sc_mirror;
    axi_wr(8'h1C, 32'hFFFF_FFAB, 4'h1);
    check("mirror bus", 32'hAB, processor_status_word_o[15:8]);
    @(posedge clk_sys_i);
    io_addr_i  <= 16'h0078;
    io_wdata_i <= 8'h5A;
    io_we_i    <= 1'b1;
    @(posedge clk_sys_i);
    io_we_i    <= 1'b0;
    settle;
    check("mirror io", 32'h5A, processor_status_word_o[15:8]);
    check("mirror rd", 32'h5A, io_rdata_o);
  endtask

  // every direct pointer value and eight bank pointer values through the conversions
  task automatic sc_convert;
    for (int d = 0; d < 8; d++) begin
      ex_wr(3'h6, {3'(d), 2'(d), 3'(d), 8'h30});
      dir_addr_i <= 8'hFF;
      slot_sel_i <= 3'(7 - d);
      settle;
      check("dir", (d == 0) ? 32'hFF : 32'(255 + 128 * d),
            dir_map_addr_o);
      check("slot", 32'(256 + 8 * (4 * d + d % 4) + 7 - d),
            bank_slot_addr_o);
      @(posedge clk_sys_i);
      dir_addr_i <= 8'h7F;
      settle;
      check("dir low", 32'h7F, dir_map_addr_o);
    end
  endtask

  // every enable and level combination
  task automatic sc_irq;
    for (int k = 0; k < 64; k++) begin
      ex_wr(3'h6, {8'h00, 1'b0, 1'(k >> 4), 2'(k >> 2), 4'h0});
      irq_req_i   <= ~1'(k >> 5);
      irq_level_i <= 2'(k);
      settle;
      check("take", 32'((k < 32) && k[4] && (k[1:0] < k[3:2])),
            irq_take_o);
    end
  endtask

  // alu steps from a preset status with every arithmetic flag set and interrupt enable clear
  task automatic sc_alu;
    for (int i = 0; i < 11; i++) begin
      ex_wr(3'h1, ACC_IN[i]);
      ex_wr(3'h2, (i == 9) ? 16'h0000 : 16'h0001);
      ex_wr(3'h6, 16'h00BF);
      @(posedge clk_sys_i);
      alu_go_i    <= 1'b1;
      alu_op_i    <= OPS[i];
      alu_wide_i  <= WIDE[i];
      alu_fmask_i <= (i == 10) ? 5'h0E : 5'h1F;
      @(posedge clk_sys_i);
      alu_go_i    <= 1'b0;
      @(negedge clk_sys_i);
      check("acc", ACC_OUT[i], main_accumulator_o);
      check("flags", {FLG[i][4], 3'h3, FLG[i][3:0]},
            processor_status_word_o[7:0]);
    end
  endtask

  // reset, then every scenario in turn
  initial begin
    {rst_b_i, ex_we_i, alu_go_i, alu_wide_i, io_we_i, irq_req_i} = '0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = '0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
    {s_axi_wdata_i, s_axi_wstrb_i, ex_sel_i, ex_data_i, alu_fmask_i} = '0;
    {io_addr_i, io_wdata_i, dir_addr_i, slot_sel_i, irq_level_i} = '0;
    alu_op_i = CPS_OP_ADD;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(negedge clk_sys_i);
    sc_reset;
    sc_regs;
    sc_mirror;
    sc_convert;
    sc_irq;
    sc_alu;
    results;
  end

  // cut a hung run short
  initial begin
    #400000;
    num_errors++;
    results;
  end
endmodule
